// ===== design/dmsa_pkg.sv
// Shared constants and types for the data-memory sector addressing block
package dmsa_pkg;
  // Special-function offsets shared by every sector
  localparam logic [7:0] OFF_PORT0 = 8'h00;
  localparam logic [7:0] OFF_PTR0 = 8'h01;
  localparam logic [7:0] OFF_PORT1 = 8'h02;
  localparam logic [7:0] OFF_P1_OFF = 8'h03;
  localparam logic [7:0] OFF_P1_SEC = 8'h04;
  localparam logic [7:0] OFF_PORT2 = 8'h0C;
  localparam logic [7:0] OFF_P2_OFF = 8'h0D;
  localparam logic [7:0] OFF_P2_SEC = 8'h0E;
  // Region boundaries
  localparam logic [7:0] GP_BASE = 8'h80;
  localparam logic [7:0] LCD_FIRST = 8'h80;
  localparam logic [7:0] LCD_LAST = 8'hB0;
  localparam logic [7:0] LCD_SECTOR = 8'h01;
  localparam logic [7:0] SECTOR_ZERO = 8'h00;
  // Sizes
  localparam int ADDR_BITS = 13;
  localparam int NUM_SECTORS_DEF = 17;
  localparam int SECTOR_GP_BYTES = 128;
  localparam int LCD_BYTES = 49;
  localparam int SFR_BYTES = 128;
  // Values
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] SFR_RESET = 8'h00;
  localparam logic [127:0] SFR_IMPL_DEF = 128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
  localparam logic [127:0] SFR_RO_DEF = 128'h0000_0000_0000_0000_0000_0000_0000_0000;

  typedef enum logic [1:0] {
    kind_none,
    kind_sfr,
    kind_gp,
    kind_lcd
  } target_kind_t;

  // True for the three offsets that redirect through a pointer
  function automatic logic is_port(input logic [7:0] off);
    return (off == OFF_PORT0) || (off == OFF_PORT1) || (off == OFF_PORT2);
  endfunction
endpackage

// ===== design/addr_resolve_if.sv
// Request and resolved target carried between the top and its resolver
`timescale 1ns/1ns
interface addr_resolve_if #(
  parameter int GP_AW = 11
);
  logic ext;
  logic [dmsa_pkg::ADDR_BITS-1:0] addr;
  logic [7:0] ptr0;
  logic [7:0] p1_off;
  logic [7:0] p1_sec;
  logic [7:0] p2_off;
  logic [7:0] p2_sec;
  dmsa_pkg::target_kind_t kind;
  logic indirect;
  logic via_pair;
  logic port_loop;
  logic [7:0] sector;
  logic [7:0] offset;
  logic [GP_AW-1:0] gp_index;
  logic [5:0] lcd_index;

  modport resolver (
    input ext, addr, ptr0, p1_off, p1_sec, p2_off, p2_sec,
    output kind, indirect, via_pair, port_loop, sector, offset, gp_index, lcd_index
  );
  modport user (
    output ext, addr, ptr0, p1_off, p1_sec, p2_off, p2_sec,
    input kind, indirect, via_pair, port_loop, sector, offset, gp_index, lcd_index
  );
endinterface

// ===== design/addr_resolver.sv
// Combinational translation of a core address into a physical target
`timescale 1ns/1ns
module addr_resolver #(
  parameter int NUM_SECTORS = dmsa_pkg::NUM_SECTORS_DEF,
  parameter int GP_AW = 11
) (
  addr_resolve_if.resolver r
);
  logic [7:0] raw_off;
  logic [7:0] sec;
  logic [7:0] off;
  logic [7:0] bank;
  logic [7:0] lcd_rel;
  logic in_display;

  always_comb begin
    raw_off = r.addr[7:0];
    sec = dmsa_pkg::SECTOR_ZERO;
    off = raw_off;
    r.indirect = 1'b0;
    r.via_pair = 1'b0;
    if (r.ext) begin
      sec = {3'b000, r.addr[12:8]};
    end
    // Ports are common to all sectors, so the sector of the access is irrelevant
    if (raw_off == dmsa_pkg::OFF_PORT0) begin
      r.indirect = 1'b1;
      sec = dmsa_pkg::SECTOR_ZERO;
      off = r.ptr0;
    end else if (raw_off == dmsa_pkg::OFF_PORT1) begin
      r.indirect = 1'b1;
      r.via_pair = 1'b1;
      sec = r.p1_sec;
      off = r.p1_off;
    end else if (raw_off == dmsa_pkg::OFF_PORT2) begin
      r.indirect = 1'b1;
      r.via_pair = 1'b1;
      sec = r.p2_sec;
      off = r.p2_off;
    end
    in_display = (off >= dmsa_pkg::LCD_FIRST) && (off <= dmsa_pkg::LCD_LAST);
    r.port_loop = r.indirect && dmsa_pkg::is_port(off);
    if (r.port_loop) begin
      r.kind = dmsa_pkg::kind_none;
    end else if (off < dmsa_pkg::GP_BASE) begin
      r.kind = dmsa_pkg::kind_sfr;
    end else if (sec == dmsa_pkg::LCD_SECTOR) begin
      if (in_display && r.via_pair) begin
        r.kind = dmsa_pkg::kind_lcd;
      end else if (in_display) begin
        r.kind = dmsa_pkg::kind_gp;
        sec = dmsa_pkg::SECTOR_ZERO;
      end else begin
        r.kind = dmsa_pkg::kind_none;
      end
    end else if (sec < 8'(NUM_SECTORS)) begin
      r.kind = dmsa_pkg::kind_gp;
    end else begin
      r.kind = dmsa_pkg::kind_none;
    end
    // Sector 1 holds no general RAM, so banks pack without a hole
    bank = (sec == dmsa_pkg::SECTOR_ZERO) ? 8'h00 : sec - 8'h01;
    lcd_rel = off - dmsa_pkg::LCD_FIRST;
    r.gp_index = {bank[GP_AW-8:0], off[6:0]};
    r.lcd_index = lcd_rel[5:0];
    r.sector = sec;
    r.offset = off;
  end
endmodule // addr_resolver

// ===== design/data_memory_sector_addressing.sv
// Data-memory decoder with pointers, indirect ports, general and display RAM
`timescale 1ns/1ns
module data_memory_sector_addressing #(
  parameter int NUM_SECTORS = dmsa_pkg::NUM_SECTORS_DEF,
  parameter logic [127:0] SFR_IMPL = dmsa_pkg::SFR_IMPL_DEF,
  parameter logic [127:0] SFR_RO = dmsa_pkg::SFR_RO_DEF
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Core access request
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_ext,
  input wire logic [dmsa_pkg::ADDR_BITS-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_bit_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic i_bit_val,
  // Read answer
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Display RAM update stream
  output logic o_lcd_wr,
  output logic [5:0] o_lcd_index,
  output logic [7:0] o_lcd_data
);
  localparam int GP_BYTES = (NUM_SECTORS - 1) * dmsa_pkg::SECTOR_GP_BYTES;
  localparam int GP_AW = $clog2(GP_BYTES);

  logic [7:0] sector0_pointer;
  logic [7:0] pair1_offset_pointer;
  logic [7:0] pair1_sector_pointer;
  logic [7:0] pair2_offset_pointer;
  logic [7:0] pair2_sector_pointer;
  logic [7:0] gp_ram [0:GP_BYTES-1];
  logic [7:0] lcd_ram [0:dmsa_pkg::LCD_BYTES-1];
  logic [7:0] sfr_mem [0:dmsa_pkg::SFR_BYTES-1];
  logic [7:0] cur_value;
  logic [7:0] next_value;
  logic [7:0] bit_mask;
  logic sfr_is_ptr;
  logic sfr_store;
  logic do_write;

  addr_resolve_if #(.GP_AW(GP_AW)) res ();

  assign res.ext = i_ext;
  assign res.addr = i_addr;
  assign res.ptr0 = sector0_pointer;
  assign res.p1_off = pair1_offset_pointer;
  assign res.p1_sec = pair1_sector_pointer;
  assign res.p2_off = pair2_offset_pointer;
  assign res.p2_sec = pair2_sector_pointer;

  addr_resolver #(
    .NUM_SECTORS(NUM_SECTORS),
    .GP_AW(GP_AW)
  ) u_resolver (
    .r(res)
  );

  assign sfr_is_ptr = (res.offset == dmsa_pkg::OFF_PTR0) ||
                      (res.offset == dmsa_pkg::OFF_P1_OFF) ||
                      (res.offset == dmsa_pkg::OFF_P1_SEC) ||
                      (res.offset == dmsa_pkg::OFF_P2_OFF) ||
                      (res.offset == dmsa_pkg::OFF_P2_SEC);
  // Plain special locations that actually hold a byte here
  assign sfr_store = SFR_IMPL[res.offset[6:0]] && !sfr_is_ptr &&
                     !dmsa_pkg::is_port(res.offset);
  assign do_write = i_wr && (res.kind != dmsa_pkg::kind_none);

  // Current contents of the resolved target
  always_comb begin
    cur_value = dmsa_pkg::READ_ZERO;
    case (res.kind)
      dmsa_pkg::kind_sfr: begin
        if (res.offset == dmsa_pkg::OFF_PTR0) begin
          cur_value = sector0_pointer;
        end else if (res.offset == dmsa_pkg::OFF_P1_OFF) begin
          cur_value = pair1_offset_pointer;
        end else if (res.offset == dmsa_pkg::OFF_P1_SEC) begin
          cur_value = pair1_sector_pointer;
        end else if (res.offset == dmsa_pkg::OFF_P2_OFF) begin
          cur_value = pair2_offset_pointer;
        end else if (res.offset == dmsa_pkg::OFF_P2_SEC) begin
          cur_value = pair2_sector_pointer;
        end else if (sfr_store) begin
          cur_value = sfr_mem[res.offset[6:0]];
        end else begin
          cur_value = dmsa_pkg::READ_ZERO;
        end
      end
      dmsa_pkg::kind_gp: cur_value = gp_ram[res.gp_index];
      dmsa_pkg::kind_lcd: cur_value = lcd_ram[res.lcd_index];
      default: cur_value = dmsa_pkg::READ_ZERO;
    endcase
  end

  // Bit set and clear act on the current byte in the same cycle
  always_comb begin
    bit_mask = 8'h01 << i_bit_sel;
    if (i_bit_op && i_bit_val) begin
      next_value = cur_value | bit_mask;
    end else if (i_bit_op) begin
      next_value = cur_value & ~bit_mask;
    end else begin
      next_value = i_wdata;
    end
  end

  // Pointer storage
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sector0_pointer <= dmsa_pkg::PTR_RESET;
      pair1_offset_pointer <= dmsa_pkg::PTR_RESET;
      pair1_sector_pointer <= dmsa_pkg::PTR_RESET;
      pair2_offset_pointer <= dmsa_pkg::PTR_RESET;
      pair2_sector_pointer <= dmsa_pkg::PTR_RESET;
    end else if (do_write && res.kind == dmsa_pkg::kind_sfr) begin
      if (res.offset == dmsa_pkg::OFF_PTR0) begin
        sector0_pointer <= next_value;
      end else if (res.offset == dmsa_pkg::OFF_P1_OFF) begin
        pair1_offset_pointer <= next_value;
      end else if (res.offset == dmsa_pkg::OFF_P1_SEC) begin
        pair1_sector_pointer <= next_value;
      end else if (res.offset == dmsa_pkg::OFF_P2_OFF) begin
        pair2_offset_pointer <= next_value;
      end else if (res.offset == dmsa_pkg::OFF_P2_SEC) begin
        pair2_sector_pointer <= next_value;
      end
    end
  end

  // Other special locations; read-only ones keep their contents
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int k = 0; k < dmsa_pkg::SFR_BYTES; k++) begin
        sfr_mem[k] <= dmsa_pkg::SFR_RESET;
      end
    end else if (do_write && res.kind == dmsa_pkg::kind_sfr && sfr_store &&
                 !SFR_RO[res.offset[6:0]]) begin
      sfr_mem[res.offset[6:0]] <= next_value;
    end
  end

  // General RAM is not cleared by reset, like ordinary data memory
  always_ff @(posedge i_clk) begin
    if (!i_reset && do_write && res.kind == dmsa_pkg::kind_gp) begin
      gp_ram[res.gp_index] <= next_value;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset && do_write && res.kind == dmsa_pkg::kind_lcd) begin
      lcd_ram[res.lcd_index] <= next_value;
    end
  end

  // Display stream mirrors each display RAM write one cycle later
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_lcd_wr <= 1'b0;
      o_lcd_index <= 6'h00;
      o_lcd_data <= 8'h00;
    end else begin
      o_lcd_wr <= do_write && (res.kind == dmsa_pkg::kind_lcd);
      if (do_write && res.kind == dmsa_pkg::kind_lcd) begin
        o_lcd_index <= res.lcd_index;
        o_lcd_data <= next_value;
      end
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= dmsa_pkg::READ_ZERO;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= cur_value;
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence rd_req_s;
    i_rd && !i_wr;
  endsequence

  sequence gp_full_write_s;
    i_wr && !i_bit_op && res.kind == dmsa_pkg::kind_gp;
  endsequence

  // Same RAM byte, whatever address form reached it
  sequence same_addr_read_s;
    i_rd && !i_wr && res.kind == dmsa_pkg::kind_gp && res.gp_index == $past(res.gp_index);
  endsequence

  read_latency_a: assert property (i_rd |=> o_rvalid)
    else $error("read answer missing");

  port_loop_read_a: assert property (rd_req_s ##0 res.port_loop |=>
    o_rdata == dmsa_pkg::READ_ZERO)
    else $error("port loop read not zero");

  unimpl_zero_a: assert property (rd_req_s ##0 res.kind == dmsa_pkg::kind_sfr &&
    !SFR_IMPL[res.offset[6:0]] && !sfr_is_ptr |=> o_rdata == dmsa_pkg::READ_ZERO)
    else $error("unused location read not zero");

  ro_hold_a: assert property (i_wr && res.kind == dmsa_pkg::kind_sfr && sfr_store &&
    SFR_RO[res.offset[6:0]] |=> sfr_mem[$past(res.offset[6:0])] == $past(cur_value))
    else $error("read-only location changed");

  port_write_none_a: assert property (i_wr && res.port_loop |=>
    $stable(sector0_pointer) && $stable(pair1_sector_pointer) &&
    $stable(pair1_offset_pointer) && $stable(pair2_offset_pointer) &&
    $stable(pair2_sector_pointer) && !o_lcd_wr)
    else $error("port loop write changed state");

  ptr_update_a: assert property (i_wr && res.kind == dmsa_pkg::kind_sfr &&
    res.offset == dmsa_pkg::OFF_P1_SEC |=> pair1_sector_pointer == $past(next_value))
    else $error("sector pointer not updated");

  lcd_route_a: assert property (i_wr && res.via_pair &&
    res.sector == dmsa_pkg::LCD_SECTOR && res.offset >= dmsa_pkg::LCD_FIRST &&
    res.offset <= dmsa_pkg::LCD_LAST |=> o_lcd_wr && o_lcd_data == $past(next_value))
    else $error("display write not routed");

  direct_display_a: assert property (!res.indirect &&
    i_addr[7:0] >= dmsa_pkg::LCD_FIRST &&
    i_addr[7:0] <= dmsa_pkg::LCD_LAST && (!i_ext || i_addr[12:8] <= 5'h01) |->
    res.kind == dmsa_pkg::kind_gp && res.gp_index[GP_AW-1:7] == '0)
    else $error("direct display access misrouted");

  port_zero_sector_a: assert property (i_addr[7:0] == dmsa_pkg::OFF_PORT0 |->
    res.sector == dmsa_pkg::SECTOR_ZERO && res.offset == sector0_pointer)
    else $error("port zero left sector zero");

  write_read_a: assert property (gp_full_write_s ##1 same_addr_read_s |=>
    o_rdata == $past(i_wdata, 2))
    else $error("general RAM write lost");

  bit_op_a: assert property (i_wr && i_bit_op && res.kind == dmsa_pkg::kind_gp |=>
    gp_ram[$past(res.gp_index)][$past(i_bit_sel)] == $past(i_bit_val))
    else $error("bit operation wrong");

  bit_keep_a: assert property (i_wr && i_bit_op && res.kind == dmsa_pkg::kind_gp |=>
    (gp_ram[$past(res.gp_index)] & ~(8'h01 << $past(i_bit_sel))) ==
    ($past(cur_value) & ~(8'h01 << $past(i_bit_sel))))
    else $error("bit operation disturbed other bits");

  rvalid_pulse_a: assert property (!i_rd |=> !o_rvalid)
    else $error("read answer without request");

  unmapped_read_a: assert property (rd_req_s ##0 res.kind == dmsa_pkg::kind_none
    |=> o_rdata == dmsa_pkg::READ_ZERO)
    else $error("unmapped read not zero");

  pair_one_target_a: assert property (i_addr[7:0] == dmsa_pkg::OFF_PORT1 |->
    res.sector == pair1_sector_pointer && res.offset == pair1_offset_pointer)
    else $error("pair one target wrong");

  pair_two_target_a: assert property (i_addr[7:0] == dmsa_pkg::OFF_PORT2 |->
    res.sector == pair2_sector_pointer && res.offset == pair2_offset_pointer)
    else $error("pair two target wrong");

  port_zero_lcd_a: assert property (i_addr[7:0] == dmsa_pkg::OFF_PORT0 |->
    res.kind != dmsa_pkg::kind_lcd)
    else $error("port zero reached display");

  // Sector 1 is left out: its display window folds back to sector 0
  ext_sector_a: assert property (i_ext && !res.indirect &&
    i_addr[7:0] >= dmsa_pkg::GP_BASE && i_addr[12:8] != 5'h01 |->
    res.sector == {3'b000, i_addr[12:8]} && res.offset == i_addr[7:0])
    else $error("extended address split wrong");

  sfr_shared_a: assert property (!res.indirect && i_addr[7:0] < dmsa_pkg::GP_BASE
    |-> res.kind == dmsa_pkg::kind_sfr && res.offset == i_addr[7:0])
    else $error("special location not shared");

  // Only a pair write into the sector 1 window may reach the display
  lcd_source_a: assert property (o_lcd_wr |-> $past(i_wr && res.via_pair &&
    res.sector == dmsa_pkg::LCD_SECTOR && res.offset >= dmsa_pkg::LCD_FIRST &&
    res.offset <= dmsa_pkg::LCD_LAST))
    else $error("display written by direct access");
endmodule // data_memory_sector_addressing

// ===== testbench/core_model.sv
// Processor-core stand-in issuing direct and indirect data accesses
`timescale 1ns/1ns
module core_model (
  // Clock
  input wire logic i_clk,
  // Request to the decoder
  output logic o_rd,
  output logic o_wr,
  output logic o_ext,
  output logic [12:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_bit_op,
  output logic [2:0] o_bit_sel,
  output logic o_bit_val
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_ext = 1'b0;
    o_addr = 13'h0000;
    o_wdata = 8'h00;
    o_bit_op = 1'b0;
    o_bit_sel = 3'h0;
    o_bit_val = 1'b0;
  end

  // Launched just after an edge, held until the next edge takes it
  task automatic issue(input logic rd, input logic wr, input logic ext, input logic [7:0] sec,
                       input logic [7:0] off, input logic [7:0] wdata, input logic bop,
                       input logic [2:0] sel, input logic val);
    @(posedge i_clk);
    #2;
    o_rd = rd;
    o_wr = wr;
    o_ext = ext;
    // Standard accesses carry junk above the offset: the decoder must ignore it
    o_addr = ext ? {sec[4:0], off} : {5'($urandom), off};
    o_wdata = wdata;
    o_bit_op = bop;
    o_bit_sel = sel;
    o_bit_val = val;
  endtask

  // Released request lines drop and address and data change; ext and the bit select and value keep their last value
  task automatic idle();
    @(posedge i_clk);
    #2;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_bit_op = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask

  // Display sector selected before any display access
  task automatic open_display(input logic [7:0] sec_ptr);
    issue(1'b0, 1'b1, 1'b0, 8'h00, sec_ptr, dmsa_pkg::LCD_SECTOR, 1'b0, 3'h0, 1'b0);
  endtask
endmodule // core_model

// ===== testbench/testbench.sv
// Self-checking bench for the data-memory sector decoder
`timescale 1ns/1ns
module testbench;
  localparam logic [127:0] IMPL = dmsa_pkg::SFR_IMPL_DEF & ~(128'h0001 << 8'h30);
  localparam logic [127:0] RO = 128'h0001 << 8'h31;
  localparam logic [7:0] PTRS [5] = '{dmsa_pkg::OFF_PTR0, dmsa_pkg::OFF_P1_OFF,
    dmsa_pkg::OFF_P1_SEC, dmsa_pkg::OFF_P2_OFF, dmsa_pkg::OFF_P2_SEC};
  localparam logic [7:0] SECP [2] = '{dmsa_pkg::OFF_P1_SEC, dmsa_pkg::OFF_P2_SEC};
  localparam logic [7:0] OFFP [2] = '{dmsa_pkg::OFF_P1_OFF, dmsa_pkg::OFF_P2_OFF};
  localparam logic [7:0] PORT [2] = '{dmsa_pkg::OFF_PORT1, dmsa_pkg::OFF_PORT2};
  logic i_clk, i_reset, rd, wr, ext, bop, bval, rvalid, lcd_wr;
  logic [12:0] addr;
  logic [7:0] wdata, rdata, lcd_data;
  logic [2:0] bsel;
  logic [5:0] lcd_idx;
  logic [7:0] rd_q [$];
  logic [13:0] lcd_q [$];
  logic [8:0] exp_r;
  logic [14:0] exp_l;
  int bad_count = 0;
  int total_checks = 0;

  core_model core (.i_clk(i_clk), .o_rd(rd), .o_wr(wr), .o_ext(ext), .o_addr(addr),
    .o_wdata(wdata), .o_bit_op(bop), .o_bit_sel(bsel), .o_bit_val(bval));

  data_memory_sector_addressing #(.SFR_IMPL(IMPL), .SFR_RO(RO)) dut (.i_clk(i_clk),
    .i_reset(i_reset), .i_rd(rd), .i_wr(wr), .i_ext(ext), .i_addr(addr), .i_wdata(wdata),
    .i_bit_op(bop), .i_bit_sel(bsel), .i_bit_val(bval), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_lcd_wr(lcd_wr), .o_lcd_index(lcd_idx), .o_lcd_data(lcd_data));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic do_wr(input logic e, input logic [7:0] s, input logic [7:0] o,
                       input logic [7:0] d);
    core.issue(1'b0, 1'b1, e, s, o, d, 1'b0, 3'h0, 1'b0);
  endtask

  // The expectation is noted before the request goes out
  task automatic do_rd(input logic e, input logic [7:0] s, input logic [7:0] o,
                       input logic [7:0] d);
    rd_q.push_back(d);
    core.issue(1'b1, 1'b0, e, s, o, 8'h00, 1'b0, 3'h0, 1'b0);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Every answer pulse is matched to the oldest noted expectation
  always @(posedge i_clk) begin
    #1;
    if (i_reset === 1'b0 && rvalid !== 1'b0) begin
      exp_r = rd_q.size() > 0 ? {1'b1, rd_q.pop_front()} : 9'h000;
      check("read answer", 16'(exp_r), 16'({rvalid, rdata}));
    end
    if (i_reset === 1'b0 && lcd_wr !== 1'b0) begin
      exp_l = lcd_q.size() > 0 ? {1'b1, lcd_q.pop_front()} : 15'h0000;
      check("display write", 16'(exp_l), 16'({lcd_wr, lcd_idx, lcd_data}));
    end
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    $display("[FAIL] run length expected end seen hang");
    tally_and_finish();
  end

  initial begin
    logic [7:0] v, w, o, s;
    logic [7:0] vals [17];
    logic [2:0] b;
    logic f;
    void'($urandom(76664));
    i_reset = 1'b1;
    repeat (3) @(posedge i_clk);
    #2;
    i_reset = 1'b0;
    foreach (PTRS[i]) do_rd(1'b0, 8'h00, PTRS[i], dmsa_pkg::PTR_RESET);
    foreach (PTRS[i]) begin
      v = 8'($urandom);
      do_wr(1'b0, 8'h00, PTRS[i], v);
      do_rd(1'b0, 8'h00, PTRS[i], v);
    end
    done("pointers");
    // One offset in every sector but sector 1, so a dropped sector bit shows as aliasing
    o = 8'h80 | 8'($urandom);
    for (int k = 0; k < dmsa_pkg::NUM_SECTORS_DEF; k++) begin
      vals[k] = 8'($urandom);
      if (k != 1) do_wr(1'b1, 8'(k), o, vals[k]);
    end
    for (int k = 0; k < dmsa_pkg::NUM_SECTORS_DEF; k++) begin
      if (k != 1) do_rd(1'b1, 8'(k), o, vals[k]);
    end
    done("extended direct");
    v = 8'($urandom);
    do_wr(1'b1, 8'h07, 8'h20, v);
    do_rd(1'b0, 8'h00, 8'h20, v);
    do_rd(1'b1, 8'h0C, 8'h20, v);
    do_wr(1'b0, 8'h00, 8'h30, 8'hA5);
    do_rd(1'b0, 8'h00, 8'h30, dmsa_pkg::READ_ZERO);
    do_wr(1'b0, 8'h00, 8'h31, 8'h5A);
    do_rd(1'b0, 8'h00, 8'h31, dmsa_pkg::SFR_RESET);
    // Targets with no storage must not alias onto a real bank
    do_wr(1'b1, 8'h01, 8'hC0, 8'h3C);
    do_rd(1'b1, 8'h01, 8'hC0, dmsa_pkg::READ_ZERO);
    do_wr(1'b1, 8'h11, 8'hC0, 8'h3C);
    do_rd(1'b1, 8'h11, 8'hC0, dmsa_pkg::READ_ZERO);
    done("special locations");
    for (int k = 0; k < 2; k++) begin
      core.open_display(SECP[k]);
      for (int j = 0; j < 2; j++) begin
        o = j ? dmsa_pkg::LCD_LAST : dmsa_pkg::LCD_FIRST;
        v = 8'($urandom);
        do_wr(1'b0, 8'h00, OFFP[k], o);
        lcd_q.push_back({6'(o - dmsa_pkg::LCD_FIRST), v});
        do_wr(1'b0, 8'h00, PORT[k], v);
        do_rd(1'b0, 8'h00, PORT[k], v);
      end
    end
    core.open_display(SECP[0]);
    do_wr(1'b0, 8'h00, OFFP[0], 8'h85);
    v = 8'($urandom);
    w = ~v;
    lcd_q.push_back({6'h05, v});
    do_wr(1'b0, 8'h00, PORT[0], v);
    do_wr(1'b0, 8'h00, 8'h85, w);
    do_rd(1'b0, 8'h00, 8'h85, w);
    do_rd(1'b1, 8'h01, 8'h85, w);
    do_rd(1'b0, 8'h00, PORT[0], v);
    done("display");
    // Pointer aimed at a port: a chained write through pair one would pulse the display stream
    do_wr(1'b0, 8'h00, dmsa_pkg::OFF_PTR0, dmsa_pkg::OFF_PORT1);
    do_rd(1'b0, 8'h00, dmsa_pkg::OFF_PORT0, dmsa_pkg::READ_ZERO);
    do_wr(1'b0, 8'h00, dmsa_pkg::OFF_PORT0, 8'h77);
    do_rd(1'b0, 8'h00, PORT[0], v);
    do_wr(1'b0, 8'h00, SECP[1], 8'h00);
    do_wr(1'b0, 8'h00, OFFP[1], dmsa_pkg::OFF_PORT2);
    do_rd(1'b0, 8'h00, PORT[1], dmsa_pkg::READ_ZERO);
    done("port loop");
    w = 8'($urandom);
    v = ~w;
    do_wr(1'b1, 8'h02, 8'h90, w);
    do_wr(1'b0, 8'h00, SECP[0], 8'h02);
    do_wr(1'b0, 8'h00, dmsa_pkg::OFF_PTR0, 8'h90);
    do_wr(1'b0, 8'h00, dmsa_pkg::OFF_PORT0, v);
    do_rd(1'b0, 8'h00, 8'h90, v);
    do_rd(1'b1, 8'h02, 8'h90, w);
    do_rd(1'b0, 8'h00, dmsa_pkg::OFF_PORT0, v);
    done("sector zero port");
    for (int n = 0; n < 4; n++) begin
      s = 8'h02 + 8'($urandom_range(14));
      o = 8'h80 | 8'($urandom);
      v = 8'($urandom);
      do_wr(1'b0, 8'h00, SECP[n % 2], s);
      do_wr(1'b0, 8'h00, OFFP[n % 2], o);
      do_wr(1'b0, 8'h00, PORT[n % 2], v);
      do_rd(1'b1, s, o, v);
    end
    done("pair ports");
    v = 8'($urandom);
    do_wr(1'b0, 8'h00, 8'hA0, v);
    for (int n = 0; n < 6; n++) begin
      b = 3'($urandom);
      f = 1'($urandom);
      core.issue(1'b0, 1'b1, 1'b0, 8'h00, 8'hA0, ~v, 1'b1, b, f);
      v[b] = f;
    end
    do_rd(1'b0, 8'h00, 8'hA0, v);
    // Read and write together: the read sees the byte before the write
    rd_q.push_back(v);
    core.issue(1'b1, 1'b1, 1'b0, 8'h00, 8'hA0, ~v, 1'b0, 3'h0, 1'b0);
    do_rd(1'b0, 8'h00, 8'hA0, ~v);
    done("bit operations");
    core.idle();
    for (int n = 0; n < 10 && (rd_q.size() + lcd_q.size()) > 0; n++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
    if ((rd_q.size() + lcd_q.size()) > 0) begin
      bad_count++;
      $display("[FAIL] answers expected all seen %0d missing", rd_q.size() + lcd_q.size());
    end
    tally_and_finish();
  end
endmodule // testbench
